/* File: verilog/pcio_pkg.sv */
// Constants shared by the configurable pad cell and its bench.
// Assumes a single 50 MHz system clock and a classic Wishbone bus.
package pcio_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADR_CFG    = 4'h0;
  localparam logic [3:0]  ADR_STATUS = 4'h4;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int          CFG_W      = 12;
  localparam int          CFG_MODE   = 0;
  localparam int          CFG_OREG   = 2;
  localparam int          CFG_OINV   = 3;
  localparam int          CFG_TINV   = 4;
  localparam int          CFG_SLOW   = 5;
  localparam int          CFG_IREG   = 6;
  localparam int          CFG_LATCH  = 7;
  localparam int          CFG_PULL   = 8;
  localparam int          CFG_EDGE   = 9;
  localparam int          CFG_LINE   = 11;

  // Unconfigured cell: input, driver off, pull-up on.
  localparam logic [11:0] CFG_RST    = 12'h100;

  // ----------------------------------------------------------------
  // Pad modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_IN    = 2'h0;
  localparam logic [1:0]  MODE_OUT   = 2'h1;
  localparam logic [1:0]  MODE_BIDIR = 2'h2;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int          ST_PAD     = 0;
  localparam int          ST_OQ      = 1;
  localparam int          ST_IQ      = 2;
  localparam int          ST_CLK     = 3;

  // ----------------------------------------------------------------
  // I/O clock lines: two per die edge, four edges
  // ----------------------------------------------------------------
  localparam int          NUM_EDGES  = 4;
  localparam int          LINES_EDGE = 2;
  localparam int          NUM_IOCLK  = 8;

endpackage

/* File: verilog/pcio_cell.sv */
// Configurable pad input/output cell with a Wishbone configuration port.
// Assumes the pad, fabric and I/O clock lines are synchronous to clk_i,
// and that the I/O clock lines run well below half the clk_i rate.
//
// How it works
// RULE1 - Output fed direct or from output register
// RULE2 - Output data and float control invertible
// RULE3 - Per-cell fast or slow edge rate
// RULE4 - Input delivered direct or through storage
// RULE5 - Input storage may act as latch
// RULE6 - Pull-up only in pure input mode
// RULE7 - Unconfigured cell: input, no drive, pull-up
// RULE8 - Float control high means pad floats
// RULE9 - Eight clock lines, two per die edge
// RULE10 - No clock inversion; pick other edge line
// RULE11 - True/inverted pair limits edge to one clock
// RULE12 - Latch transparent low, holds while high
// RULE13 - Latch captures at flip-flop's active edge
// RULE14 - All cell storage uses one chosen line
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module pcio_cell (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // I/O clock lines
  input  wire logic [7:0]  io_clk_i,
  // Fabric side
  input  wire logic        fab_out_i,
  input  wire logic        fab_float_i,
  output logic             fab_in_o,
  // Pad side
  input  wire logic        pad_i,
  output logic             pad_o,
  output logic             pad_oe_o,
  output logic             pad_pullup_o,
  output logic             pad_slow_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] cfg;
    logic        clk_prev;
    logic        oq;
    logic        iq;
    logic        pad_out;
    logic        pad_oe;
    logic        pull;
    logic        slow;
    logic        fab_in;
    logic        ack;
    logic [31:0] dat;
  } pcio_state_t;

  pcio_state_t st_ff;
  pcio_state_t nxt_st;

  logic [1:0] mode;
  logic [2:0] clk_idx;
  logic       sel_clk;
  logic       clk_rise;
  logic       is_input;
  logic       out_bit;
  logic       float_bit;
  logic       req;

  // ----------------------------------------------------------------
  // Decode of the configuration
  // ----------------------------------------------------------------
  assign mode     = st_ff.cfg[pcio_pkg::CFG_MODE +: 2];
  // Edge number picks the pair, line bit picks within the pair.
  assign clk_idx  = {st_ff.cfg[pcio_pkg::CFG_EDGE +: 2],
                     st_ff.cfg[pcio_pkg::CFG_LINE]};      // see RULE9
  // There is no inverter here: the opposite edge comes from the
  // partner line of the pair when it carries the inverted clock.
  assign sel_clk  = io_clk_i[clk_idx];                    // see RULE10
  assign clk_rise = sel_clk & ~st_ff.clk_prev;
  // The reserved mode code falls back to the safe input behaviour.
  assign is_input = (mode != pcio_pkg::MODE_OUT) &&
                    (mode != pcio_pkg::MODE_BIDIR);
  assign req      = cyc_i & stb_i & ~st_ff.ack;

  assign out_bit   = (st_ff.cfg[pcio_pkg::CFG_OREG] ? st_ff.oq : fab_out_i)
                     ^ st_ff.cfg[pcio_pkg::CFG_OINV];     // see RULE1
  assign float_bit = fab_float_i ^ st_ff.cfg[pcio_pkg::CFG_TINV]; // see RULE2

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.clk_prev = sel_clk;
    nxt_st.ack      = req;

    // Both storage elements watch only the selected line.
    // The detector remembers the last selected level, not every line.
    // Switching to a line that is high while the old one was low is
    // therefore seen as one rise; change lines while both agree.
    if (clk_rise) begin
      nxt_st.oq = fab_out_i;                              // see RULE14
    end
    if (st_ff.cfg[pcio_pkg::CFG_LATCH]) begin
      // Open while low; the last value seen before the rise is held.
      if (!sel_clk) begin                                 // see RULE13
        nxt_st.iq = pad_i;                                // see RULE12
      end
    end else if (clk_rise) begin
      nxt_st.iq = pad_i;                                  // see RULE5
    end

    nxt_st.pad_out = out_bit;
    nxt_st.pad_oe  = !is_input && !float_bit;             // see RULE8
    nxt_st.pull    = is_input &&
                     st_ff.cfg[pcio_pkg::CFG_PULL];       // see RULE6
    nxt_st.slow    = st_ff.cfg[pcio_pkg::CFG_SLOW];       // see RULE3
    nxt_st.fab_in  = st_ff.cfg[pcio_pkg::CFG_IREG] ? st_ff.iq
                                                   : pad_i; // see RULE4

    if (req && we_i && adr_i == pcio_pkg::ADR_CFG) begin
      if (sel_i[0]) begin
        nxt_st.cfg[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        nxt_st.cfg[11:8] = dat_i[11:8];
      end
    end

    nxt_st.dat = 32'h0000_0000;
    if (req && !we_i) begin
      unique case (adr_i)
        pcio_pkg::ADR_CFG: begin
          nxt_st.dat[11:0] = st_ff.cfg;
        end
        pcio_pkg::ADR_STATUS: begin
          nxt_st.dat[pcio_pkg::ST_PAD] = pad_i;
          nxt_st.dat[pcio_pkg::ST_OQ]  = st_ff.oq;
          nxt_st.dat[pcio_pkg::ST_IQ]  = st_ff.iq;
          nxt_st.dat[pcio_pkg::ST_CLK] = sel_clk;
        end
        default: begin
          nxt_st.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff      <= '0;
      st_ff.cfg  <= pcio_pkg::CFG_RST;                    // see RULE7
      st_ff.pull <= 1'b1;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign dat_o        = st_ff.dat;
  assign ack_o        = st_ff.ack;
  assign fab_in_o     = st_ff.fab_in;
  assign pad_o        = st_ff.pad_out;
  assign pad_oe_o     = st_ff.pad_oe;
  assign pad_pullup_o = st_ff.pull;
  assign pad_slow_o   = st_ff.slow;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_out_direct;
    ce_i && !st_ff.cfg[pcio_pkg::CFG_OREG]
    |=> pad_o == $past(fab_out_i ^ st_ff.cfg[pcio_pkg::CFG_OINV]);
  endproperty
  a_out_direct: assert property (p_out_direct) // see RULE1
    else $error("direct output path wrong");

  // The registered path must show the stored bit, not the live fabric bit.
  property p_out_regd;
    ce_i && st_ff.cfg[pcio_pkg::CFG_OREG]
    |=> pad_o == $past(st_ff.oq ^ st_ff.cfg[pcio_pkg::CFG_OINV]);
  endproperty
  a_out_regd: assert property (p_out_regd) // see RULE1
    else $error("registered output path wrong");

  property p_out_reg;
    ce_i && st_ff.cfg[pcio_pkg::CFG_OREG] && !clk_rise && !rst_i
    |=> $stable(st_ff.oq);
  endproperty
  a_out_reg: assert property (p_out_reg) // see RULE14
    else $error("output register moved without clock rise");

  property p_float;
    ce_i && !is_input
    |=> pad_oe_o == $past(~(fab_float_i ^ st_ff.cfg[pcio_pkg::CFG_TINV]));
  endproperty
  a_float: assert property (p_float) // see RULE2
    else $error("float control polarity wrong");

  property p_float_high;
    ce_i && (fab_float_i ^ st_ff.cfg[pcio_pkg::CFG_TINV]) |=> !pad_oe_o;
  endproperty
  a_float_high: assert property (p_float_high) // see RULE8
    else $error("pad driven while float control high");

  property p_slew;
    ce_i |=> pad_slow_o == $past(st_ff.cfg[pcio_pkg::CFG_SLOW]);
  endproperty
  a_slew: assert property (p_slew) // see RULE3
    else $error("slew setting not applied");

  property p_in_direct;
    ce_i && !st_ff.cfg[pcio_pkg::CFG_IREG] |=> fab_in_o == $past(pad_i);
  endproperty
  a_in_direct: assert property (p_in_direct) // see RULE4
    else $error("direct input path wrong");

  property p_in_stored;
    ce_i && st_ff.cfg[pcio_pkg::CFG_IREG] |=> fab_in_o == $past(st_ff.iq);
  endproperty
  a_in_stored: assert property (p_in_stored) // see RULE4
    else $error("stored input path wrong");

  // In flip-flop mode nothing but a rise of the chosen line may load.
  property p_only_sel;
    ce_i && !st_ff.cfg[pcio_pkg::CFG_LATCH] && !clk_rise
    |=> $stable(st_ff.iq);
  endproperty
  a_only_sel: assert property (p_only_sel) // see RULE14
    else $error("input flip-flop moved without clock rise");

  property p_ff_capture;
    ce_i && !st_ff.cfg[pcio_pkg::CFG_LATCH] && clk_rise
    |=> st_ff.iq == $past(pad_i);
  endproperty
  a_ff_capture: assert property (p_ff_capture) // see RULE5
    else $error("input flip-flop missed edge");

  property p_latch_open;
    ce_i && st_ff.cfg[pcio_pkg::CFG_LATCH] && !sel_clk
    |=> st_ff.iq == $past(pad_i);
  endproperty
  a_latch_open: assert property (p_latch_open) // see RULE12
    else $error("latch not transparent while low");

  property p_latch_hold;
    ce_i && st_ff.cfg[pcio_pkg::CFG_LATCH] && sel_clk && st_ff.clk_prev
    |=> $stable(st_ff.iq);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // see RULE12
    else $error("latch changed while closed");

  // At the rise the latch keeps what it saw while it was still open.
  property p_latch_capture;
    ce_i && st_ff.cfg[pcio_pkg::CFG_LATCH] && clk_rise
    |=> $stable(st_ff.iq);
  endproperty
  a_latch_capture: assert property (p_latch_capture) // see RULE13
    else $error("latch lost value at closing edge");

  property p_oe_input;
    ce_i && is_input |=> !pad_oe_o;
  endproperty
  a_oe_input: assert property (p_oe_input) // see RULE7
    else $error("pad driven in input mode");

  property p_pull_on;
    ce_i && is_input && st_ff.cfg[pcio_pkg::CFG_PULL] |=> pad_pullup_o;
  endproperty
  a_pull_on: assert property (p_pull_on) // see RULE6
    else $error("pull-up missing in input mode");

  property p_pull;
    ce_i && !is_input |=> !pad_pullup_o;
  endproperty
  a_pull: assert property (p_pull) // see RULE6
    else $error("pull-up on outside input mode");

  property p_unconf;
    disable iff (1'b0)
    rst_i |=> pad_pullup_o && !pad_oe_o &&
              st_ff.cfg[pcio_pkg::CFG_MODE +: 2] == pcio_pkg::MODE_IN;
  endproperty
  a_unconf: assert property (p_unconf) // see RULE7
    else $error("reset state not unconfigured input");

  property p_ack;
    cyc_i && stb_i && ce_i && !ack_o |=> ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not acknowledged");

  // An acknowledge must not stay high for two cycles in a row.
  property p_ack_drop;
    ce_i && ack_o |=> !ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("acknowledge held for two cycles");

  property p_read_cfg;
    ce_i && cyc_i && stb_i && !ack_o && !we_i && adr_i == pcio_pkg::ADR_CFG
    |=> dat_o[11:0] == $past(st_ff.cfg);
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("configuration read back wrong");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------

  c_latch: cover property (st_ff.cfg[pcio_pkg::CFG_LATCH] && clk_rise);
  c_oreg:  cover property (st_ff.cfg[pcio_pkg::CFG_OREG] && clk_rise && pad_oe_o);
  c_bidir: cover property (mode == pcio_pkg::MODE_BIDIR && pad_oe_o);
  c_write: cover property (ack_o && we_i);
  c_read:  cover property (ack_o && !we_i);

endmodule

/* File: tb/pcio_pad_model.sv */
// Board-side model of the signal on the pad of one pad cell.
// Assumes the cell drives pad_o only while pad_oe_o is high.
`timescale 1ns/10ps
module pcio_pad_model (
  // Clock
  input  wire logic clk_i,
  // Pad cell side
  input  wire logic pad_o,
  input  wire logic pad_oe_o,
  input  wire logic pad_pullup_o,
  // Board stimulus
  input  wire logic ext_en_i,
  input  wire logic ext_lvl_i,
  output logic      pad_i
);
  logic churn_ff = 1'b0;

  // A floating pad without pull-up wanders, so no check may rely on it.
  always_ff @(posedge clk_i) begin
    churn_ff <= ~churn_ff;
  end

  always_comb begin
    if (pad_oe_o) begin
      pad_i = pad_o;
    end else if (ext_en_i) begin
      pad_i = ext_lvl_i;
    end else if (pad_pullup_o) begin
      pad_i = 1'b1;
    end else begin
      pad_i = churn_ff;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the configurable pad cell.
// Assumes the Wishbone timing and register map of the cell's package.
`timescale 1ns/10ps
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic        we_i = 1'b0, fab_out_i = 1'b0, fab_float_i = 1'b0, ack_o, fab_in_o;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        pad_i, pad_o, pad_oe_o, pad_pullup_o, pad_slow_o;
  logic        ioc = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
  logic [7:0]  io_clk_i;
  int          bad_count = 0, comparisons = 0;

  // Line 1 of edge 0 carries the inverse of line 0.
  assign io_clk_i = {6'h00, ~ioc, ioc};

  pcio_cell dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .io_clk_i, .fab_out_i, .fab_float_i, .fab_in_o, .pad_i, .pad_o,
    .pad_oe_o, .pad_pullup_o, .pad_slow_o);
  pcio_pad_model board (.clk_i, .pad_o, .pad_oe_o, .pad_pullup_o, .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .pad_i);

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Values read after the edge returns are those settled before it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic [31:0] fld(input int n);
    return 32'h1 << n;
  endfunction

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (i == 20) begin
      bad_count++;
      complete_run();
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    chk(pad_oe_o, 1'b0);
    chk(pad_pullup_o, 1'b1);
    wb(1'b0, pcio_pkg::ADR_CFG, 32'h0);
    chk(rd, 32'h100);
    wb(1'b1, 4'h8, 32'hfff);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_out_direct;
    logic [2:0] k;
    for (int n = 0; n < 8; n++) begin
      k = 3'(n);
      wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_OUT) | fld(pcio_pkg::CFG_PULL)
        | (k[0] ? fld(pcio_pkg::CFG_OINV) | fld(pcio_pkg::CFG_SLOW) : 32'h0)
        | (k[1] ? fld(pcio_pkg::CFG_TINV) : 32'h0));
      fab_out_i   <= 1'b1;
      fab_float_i <= k[2];
      tick(4);
      chk(pad_oe_o, !(k[2] ^ k[1]));
      if (k[2] == k[1]) chk(pad_o, !k[0]);
      chk(pad_slow_o, k[0]);
      chk(pad_pullup_o, 1'b0);
    end
    wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_BIDIR) | fld(pcio_pkg::CFG_PULL));
    tick(3);
    chk(pad_pullup_o, 1'b0);
  endtask

  task automatic t_out_reg;
    fab_float_i <= 1'b0;
    wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_OUT) | fld(pcio_pkg::CFG_OREG));
    tick(4);
    chk(pad_o, 1'b0);
    ioc <= 1'b1;
    tick(4);
    chk(pad_o, 1'b1);
    fab_out_i <= 1'b0;
    ioc       <= 1'b0;
    tick(4);
    chk(pad_o, 1'b1);
    // Moving to the high partner line counts as one rise and loads a one.
    fab_out_i <= 1'b1;
    wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_OUT) | fld(pcio_pkg::CFG_OREG)
      | fld(pcio_pkg::CFG_LINE));
    ioc       <= 1'b1;
    fab_out_i <= 1'b0;
    tick(4);
    chk(pad_o, 1'b1);
    ioc <= 1'b0;
    tick(4);
    chk(pad_o, 1'b0);
  endtask

  task automatic t_input;
    wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_IN) | fld(pcio_pkg::CFG_PULL));
    tick(4);
    chk(fab_in_o, 1'b1);
    ext_en <= 1'b1;
    tick(4);
    chk(fab_in_o, 1'b0);
    wb(1'b1, pcio_pkg::ADR_CFG, fld(pcio_pkg::CFG_IREG));
    ioc <= 1'b1;
    tick(4);
    chk(fab_in_o, 1'b0);
    ext_lvl <= 1'b1;
    tick(4);
    chk(fab_in_o, 1'b0);
    ioc <= 1'b0;
    tick(4);
    chk(fab_in_o, 1'b0);
    ioc <= 1'b1;
    tick(4);
    chk(fab_in_o, 1'b1);
    wb(1'b1, pcio_pkg::ADR_CFG, fld(pcio_pkg::CFG_IREG) | fld(pcio_pkg::CFG_LATCH));
    ext_lvl <= 1'b0;
    tick(4);
    chk(fab_in_o, 1'b1);
    ioc <= 1'b0;
    tick(4);
    chk(fab_in_o, 1'b0);
    ext_lvl <= 1'b1;
    tick(4);
    chk(fab_in_o, 1'b1);
    ioc <= 1'b1;
    tick(4);
    ext_lvl <= 1'b0;
    tick(4);
    chk(fab_in_o, 1'b1);
  endtask

  task automatic t_edge;
    // Edge 1 lines stay low, so toggling edge 0 must not clock the cell.
    wb(1'b1, pcio_pkg::ADR_CFG, 32'(pcio_pkg::MODE_OUT) | fld(pcio_pkg::CFG_OREG)
      | fld(pcio_pkg::CFG_EDGE));
    fab_out_i <= 1'b1;
    ioc       <= 1'b0;
    tick(4);
    ioc <= 1'b1;
    tick(4);
    chk(pad_o, 1'b0);
    wb(1'b0, pcio_pkg::ADR_STATUS, 32'h0);
    chk(rd & 32'h0000_000b, 32'h0);
    wb(1'b1, pcio_pkg::ADR_CFG, 32'h3 | fld(pcio_pkg::CFG_PULL));
    tick(3);
    chk(pad_oe_o, 1'b0);
    chk(pad_pullup_o, 1'b1);
  endtask

  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_out_direct();
    t_out_reg();
    t_input();
    t_edge();
    complete_run();
  end
endmodule
